// ---- hw/eirq_latch.sv ----
/*
 * External interrupt latch with a dedicated active-low pin and a shared port
 * pin, edge or edge-and-level sensitivity, mask, polled flag and software
 * acknowledge over AHB-Lite.
 * Assumes pins are asynchronous to clk_sys; the vector fetch acknowledge and
 * break state come from logic on clk_sys.
 */
// Behaviour
// - Falling edge on interrupt pin sets latch.
// - Vector fetch acknowledge clears the latch.
// - Software clear strobe clears the latch.
// - Reset clears latch and sensitivity select.
// - Edge mode: acknowledge clears request immediately.
// - Level mode: clear needs acknowledge and pin high.
// - Level mode: request stays while pin low.
// - Edge after acknowledge latches a new request.
// - Request forwarded only while mask clear.
// - Mask bit disables requests, reset clears it.
// - Pending flag readable regardless of mask.
// - Vector pair at FFF8 and FFF9.
// - Clear strobe is write-only, reads zero.
// - Sensitivity bit selects edge or edge-and-level.
// - Shared pin interrupts only when enabled, USB off.
// - Shared pin ORed with dedicated pin.
// - Shared enable with USB off forces input with pullup.
// - Shared edge flag, cleared by option read.
// - Without break clear enable, break blocks clear.
// - With break clear enable, clear persists.
// - Pullup disable bit controls dedicated pullup.
module eirq_latch
    import eirq_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    input  wire logic        clk_sys,            // System clock, 250 MHz.
    input  wire logic        rst,                // Asynchronous reset, active high.
    input  wire logic        hsel,               // AHB slave select.
    input  wire logic [31:0] haddr,              // AHB address.
    input  wire logic [1:0]  htrans,             // AHB transfer type.
    input  wire logic        hwrite,             // AHB write when high.
    input  wire logic [2:0]  hsize,              // AHB transfer size.
    input  wire logic [31:0] hwdata,             // AHB write data.
    input  wire logic        hready,             // AHB bus ready.
    output logic      [31:0] hrdata,             // AHB read data.
    output logic             hreadyout,          // AHB slave ready.
    output logic             hresp,              // AHB response, always OKAY.
    input  wire logic        intPinN,            // Dedicated interrupt pin, active low.
    input  wire logic        sharedPortPin,      // Shared port pin.
    input  wire logic        vectorFetchAck,     // CPU vector fetch pulse for this interrupt.
    input  wire logic        breakActive,        // CPU is in the break state.
    output logic             irqRequest,         // Request to the priority logic.
    output logic      [15:0] vectorAddr,         // First location of the vector pair.
    output logic             intPinPullupEn,     // Pullup on the dedicated pin.
    output logic             sharedPinPullupEn,  // Pullup on the shared pin.
    output logic             sharedPinForceInput // Shared pin forced to input.
);

    // Pin synchroniser chains, one row per pin.
    logic [SYNC_STAGES-1:0] dedSync_r;
    logic [SYNC_STAGES-1:0] dedSync_nxt;
    logic [SYNC_STAGES-1:0] shSync_r;
    logic [SYNC_STAGES-1:0] shSync_nxt;
    logic                   dedLevel_r;
    logic                   dedLevel_nxt;
    logic                   shLevel_r;
    logic                   shLevel_nxt;
    // Arming chain: a pin held low through reset must not look like a fresh edge.
    logic [SYNC_STAGES:0]   armSync_r;
    logic [SYNC_STAGES:0]   armSync_nxt;

    // Control state.
    eirq_ctrl_t ctrl_r;
    eirq_ctrl_t ctrl_nxt;
    eirq_opt_t  opt_r;
    eirq_opt_t  opt_nxt;
    eirq_sys_t  sys_r;
    eirq_sys_t  sys_nxt;

    // Latch state.
    logic latch_r;
    logic latch_nxt;
    logic ackHeld_r;
    logic ackHeld_nxt;
    logic shFlag_r;
    logic shFlag_nxt;

    // Bus data phase state.
    logic       dpWrite_r;
    logic       dpWrite_nxt;
    logic [7:0] dpAddr_r;
    logic [7:0] dpAddr_nxt;
    logic [31:0] hrdata_nxt;

    // Output registers.
    logic irqRequest_nxt;
    logic intPinPullupEn_nxt;
    logic sharedPinPullupEn_nxt;
    logic sharedPinForceInput_nxt;

    // Combinational helpers.
    logic addrPhase;
    logic sharedEn;
    logic dedFall;
    logic shFall;
    logic lineLow;
    logic swClear;
    logic ackEff;
    logic optRead;

    // Builds the read word for a register offset.
    function automatic logic [31:0] readWord(
        input logic [7:0] ofs,
        input eirq_ctrl_t c,
        input eirq_opt_t  o,
        input eirq_sys_t  s,
        input logic       pend,
        input logic       flag
    );
        logic [7:0] v;
        v = EIRQ_RDATA_ZERO;
        unique case (ofs)
            EIRQ_STATUS_CTRL_OFS: begin
                v[EIRQ_SC_PENDING_BIT] = pend;
                v[EIRQ_SC_MASK_BIT]    = c.requestMask;
                v[EIRQ_SC_MODE_BIT]    = c.levelMode;
                v[EIRQ_SC_CLEAR_BIT]   = 1'b0;
            end
            EIRQ_OPTION_OFS: begin
                v[EIRQ_OPT_SHFLAG_BIT]  = flag;
                v[EIRQ_OPT_SHENA_BIT]   = o.sharedPinIntEnable;
                v[EIRQ_OPT_PULLDIS_BIT] = o.pinPullupDisable;
            end
            EIRQ_SYS_CTRL_OFS: begin
                v[EIRQ_SYS_BREAK_CLEAR_ENABLE_BIT]  = s.breakClearEnable;
                v[EIRQ_SYS_USB_FUNCTION_ENABLE_BIT] = s.usbFunctionEnable;
            end
            default: begin
                v = EIRQ_RDATA_ZERO;
            end
        endcase
        return {24'h000000, v};
    endfunction

    // Source conditioning and acknowledge qualification.
    always_comb begin
        addrPhase = hsel && hready && (htrans == EIRQ_HTRANS_NONSEQ);
        dedSync_nxt = {dedSync_r[SYNC_STAGES-2:0], intPinN};
        shSync_nxt  = {shSync_r[SYNC_STAGES-2:0], sharedPortPin};
        dedLevel_nxt = (dedSync_r[1] == dedSync_r[2]) ? dedSync_r[2] : dedLevel_r;
        shLevel_nxt  = (shSync_r[1] == shSync_r[2]) ? shSync_r[2] : shLevel_r;
        armSync_nxt = {armSync_r[SYNC_STAGES-1:0], 1'b1};
        sharedEn = opt_r.sharedPinIntEnable && !sys_r.usbFunctionEnable;
        // falling edge detect
        // Edges within the first cycles after reset are ignored until the filtered level is real.
        dedFall = armSync_r[SYNC_STAGES] && dedLevel_r && !dedLevel_nxt;
        shFall  = armSync_r[SYNC_STAGES] && shLevel_r && !shLevel_nxt;
        lineLow = !dedLevel_r || (sharedEn && !shLevel_r);
        swClear = dpWrite_r && (dpAddr_r == EIRQ_STATUS_CTRL_OFS) && hwdata[EIRQ_SC_CLEAR_BIT];
        ackEff = vectorFetchAck || (swClear && (!breakActive || sys_r.breakClearEnable));
        optRead = addrPhase && !hwrite && (haddr[7:0] == EIRQ_OPTION_OFS);
    end

    // Next state of the latch and its acknowledge memory.
    always_comb begin
        latch_nxt   = latch_r;
        ackHeld_nxt = ackHeld_r;
        if (dedFall || (sharedEn && shFall)) begin
            latch_nxt   = 1'b1;
            ackHeld_nxt = 1'b0;
        end else if (!ctrl_r.levelMode) begin
            if (ackEff) begin
                latch_nxt = 1'b0;
            end
            ackHeld_nxt = 1'b0;
        end else if (lineLow) begin
            latch_nxt = 1'b1;
            if (ackEff) begin
                ackHeld_nxt = 1'b1;
            end
        end else begin
            if (ackEff || ackHeld_r) begin
                latch_nxt = 1'b0;
            end
            ackHeld_nxt = 1'b0;
        end
    end

    // Shared edge flag: set wins over the read clear.
    always_comb begin
        if (opt_r.sharedPinIntEnable && shFall) begin
            shFlag_nxt = 1'b1;
        end else if (optRead) begin
            shFlag_nxt = 1'b0;
        end else begin
            shFlag_nxt = shFlag_r;
        end
    end

    // Register writes in the data phase and read data capture.
    always_comb begin
        ctrl_nxt    = ctrl_r;
        opt_nxt     = opt_r;
        sys_nxt     = sys_r;
        dpWrite_nxt = addrPhase && hwrite;
        dpAddr_nxt  = addrPhase ? haddr[7:0] : dpAddr_r;
        hrdata_nxt  = hrdata;
        if (dpWrite_r) begin
            unique case (dpAddr_r)
                EIRQ_STATUS_CTRL_OFS: begin
                    ctrl_nxt.requestMask = hwdata[EIRQ_SC_MASK_BIT];
                    ctrl_nxt.levelMode   = hwdata[EIRQ_SC_MODE_BIT];
                end
                EIRQ_OPTION_OFS: begin
                    opt_nxt.sharedPinIntEnable = hwdata[EIRQ_OPT_SHENA_BIT];
                    opt_nxt.pinPullupDisable   = hwdata[EIRQ_OPT_PULLDIS_BIT];
                end
                EIRQ_SYS_CTRL_OFS: begin
                    sys_nxt.breakClearEnable  = hwdata[EIRQ_SYS_BREAK_CLEAR_ENABLE_BIT];
                    sys_nxt.usbFunctionEnable = hwdata[EIRQ_SYS_USB_FUNCTION_ENABLE_BIT];
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
        if (addrPhase && !hwrite) begin
            hrdata_nxt = readWord(haddr[7:0], ctrl_r, opt_r, sys_r, latch_r, shFlag_r);
        end
    end

    // Registered outputs.
    always_comb begin
        irqRequest_nxt          = latch_nxt && !ctrl_nxt.requestMask;
        intPinPullupEn_nxt      = !opt_nxt.pinPullupDisable;
        sharedPinForceInput_nxt = opt_nxt.sharedPinIntEnable && !sys_nxt.usbFunctionEnable;
        sharedPinPullupEn_nxt   = sharedPinForceInput_nxt;
    end

    // State registers.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dedSync_r           <= '1;
            shSync_r            <= '1;
            dedLevel_r          <= 1'b1;
            shLevel_r           <= 1'b1;
            armSync_r           <= '0;
            ctrl_r              <= '{requestMask: EIRQ_MASK_RST, levelMode: EIRQ_MODE_RST};
            opt_r               <= '{sharedPinIntEnable: EIRQ_SHENA_RST, pinPullupDisable: EIRQ_PULLDIS_RST};
            sys_r               <= '{breakClearEnable: EIRQ_BREAK_CLEAR_ENABLE_RST, usbFunctionEnable: EIRQ_USB_FUNCTION_ENABLE_RST};
            latch_r             <= 1'b0;
            ackHeld_r           <= 1'b0;
            shFlag_r            <= 1'b0;
            dpWrite_r           <= 1'b0;
            dpAddr_r            <= 8'h00;
            hrdata              <= 32'h00000000;
            hreadyout           <= 1'b1;
            hresp               <= EIRQ_HRESP_OKAY;
            irqRequest          <= 1'b0;
            vectorAddr          <= EIRQ_VECTOR_HI_ADDR;
            intPinPullupEn      <= 1'b1;
            sharedPinPullupEn   <= 1'b0;
            sharedPinForceInput <= 1'b0;
        end else begin
            dedSync_r           <= dedSync_nxt;
            shSync_r            <= shSync_nxt;
            dedLevel_r          <= dedLevel_nxt;
            shLevel_r           <= shLevel_nxt;
            armSync_r           <= armSync_nxt;
            ctrl_r              <= ctrl_nxt;
            opt_r               <= opt_nxt;
            sys_r               <= sys_nxt;
            latch_r             <= latch_nxt;
            ackHeld_r           <= ackHeld_nxt;
            shFlag_r            <= shFlag_nxt;
            dpWrite_r           <= dpWrite_nxt;
            dpAddr_r            <= dpAddr_nxt;
            hrdata              <= hrdata_nxt;
            hreadyout           <= 1'b1;
            hresp               <= EIRQ_HRESP_OKAY;
            irqRequest          <= irqRequest_nxt;
            vectorAddr          <= EIRQ_VECTOR_HI_ADDR;
            intPinPullupEn      <= intPinPullupEn_nxt;
            sharedPinPullupEn   <= sharedPinPullupEn_nxt;
            sharedPinForceInput <= sharedPinForceInput_nxt;
        end
    end

endmodule

// ---- hw/eirq_pkg.sv ----
/*
 * Package for the external interrupt latch: register offsets, field
 * positions, reset values and the packed structs that carry control state.
 * Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
 */
package eirq_pkg;

    // Register byte offsets.
    localparam logic [7:0] EIRQ_STATUS_CTRL_OFS = 8'h18;
    localparam logic [7:0] EIRQ_OPTION_OFS      = 8'h1c;
    localparam logic [7:0] EIRQ_SYS_CTRL_OFS    = 8'h20;

    // Status and control register fields.
    localparam int EIRQ_SC_MODE_BIT    = 0;
    localparam int EIRQ_SC_MASK_BIT    = 1;
    localparam int EIRQ_SC_CLEAR_BIT   = 2;
    localparam int EIRQ_SC_PENDING_BIT = 3;

    // Option register fields.
    localparam int EIRQ_OPT_PULLDIS_BIT = 0;
    localparam int EIRQ_OPT_SHENA_BIT   = 1;
    localparam int EIRQ_OPT_SHFLAG_BIT  = 2;

    // System control register fields.
    localparam int EIRQ_SYS_USB_FUNCTION_ENABLE_BIT = 0;
    localparam int EIRQ_SYS_BREAK_CLEAR_ENABLE_BIT  = 1;

    // Reset values.
    localparam logic       EIRQ_MODE_RST    = 1'b0;
    localparam logic       EIRQ_MASK_RST    = 1'b0;
    localparam logic       EIRQ_PULLDIS_RST = 1'b0;
    localparam logic       EIRQ_SHENA_RST   = 1'b0;
    localparam logic       EIRQ_USB_FUNCTION_ENABLE_RST   = 1'b0;
    localparam logic       EIRQ_BREAK_CLEAR_ENABLE_RST    = 1'b0;
    localparam logic [7:0] EIRQ_RDATA_ZERO  = 8'h00;

    // Service routine vector pair locations.
    localparam logic [15:0] EIRQ_VECTOR_HI_ADDR = 16'hfff8;
    localparam logic [15:0] EIRQ_VECTOR_LO_ADDR = 16'hfff9;

    // AHB-Lite encodings.
    localparam logic [1:0] EIRQ_HTRANS_NONSEQ = 2'h2;
    localparam logic       EIRQ_HRESP_OKAY    = 1'b0;

    // Sensitivity and masking controls.
    typedef struct packed {
        logic requestMask;
        logic levelMode;
    } eirq_ctrl_t;

    // Pin option controls.
    typedef struct packed {
        logic sharedPinIntEnable;
        logic pinPullupDisable;
    } eirq_opt_t;

    // Controls owned by neighbouring units, mirrored here.
    typedef struct packed {
        logic breakClearEnable;
        logic usbFunctionEnable;
    } eirq_sys_t;

endpackage

// ---- tb/eirq_latch_monitor.sv ----
/* Checker for the external interrupt latch: request timing, masking and pin options.
   Assumes it sees only the latch's ports and is attached by the bind at its foot. */
module eirq_latch_monitor
    import eirq_pkg::*;
(
    input wire logic        clk_sys,            // Clock.
    input wire logic        rst,                // Reset.
    input wire logic        hsel,               // Select.
    input wire logic [31:0] haddr,              // Address.
    input wire logic [1:0]  htrans,             // Transfer type.
    input wire logic        hwrite,             // Write.
    input wire logic [31:0] hwdata,             // Write data.
    input wire logic        hready,             // Bus ready.
    input wire logic        intPinN,            // Dedicated pin.
    input wire logic        sharedPortPin,      // Shared pin.
    input wire logic        vectorFetchAck,     // Fetch acknowledge.
    input wire logic        breakActive,        // Break state.
    input wire logic        irqRequest,         // Request out.
    input wire logic        intPinPullupEn,     // Dedicated pullup.
    input wire logic        sharedPinPullupEn,  // Shared pullup.
    input wire logic        sharedPinForceInput // Shared input force.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wrPend_r, modeSh_r, maskSh_r, pdisSh_r, shenaSh_r, usbSh_r, bcfeSh_r;
    logic [7:0] ofs_r;
    wire        wrSc = wrPend_r && ofs_r == EIRQ_STATUS_CTRL_OFS;
    wire        shEn = shenaSh_r && !usbSh_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Shadows of the control bits, updated at the data-phase edge of each write.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {wrPend_r, modeSh_r, maskSh_r, pdisSh_r, shenaSh_r, usbSh_r, bcfeSh_r} <= 7'h00;
            ofs_r <= 8'h00;
        end else begin
            wrPend_r <= hsel && hready && htrans == EIRQ_HTRANS_NONSEQ && hwrite;
            ofs_r <= haddr[7:0];
            if (wrSc) begin
                {maskSh_r, modeSh_r} <= hwdata[1:0];
            end
            if (wrPend_r && ofs_r == EIRQ_OPTION_OFS) begin
                {shenaSh_r, pdisSh_r} <= hwdata[1:0];
            end
            if (wrPend_r && ofs_r == EIRQ_SYS_CTRL_OFS) begin
                {bcfeSh_r, usbSh_r} <= hwdata[1:0];
            end
        end
    end

    // Both pins high long enough that no edge is still in the synchroniser.
    sequence s_quiet;
        (intPinN && sharedPortPin)[*6];
    endsequence
    // A software clear in break with the request up and no fetch around it.
    sequence s_breakClr;
        !vectorFetchAck ##1 (wrSc && hwdata[2] && !hwdata[1] && breakActive && !bcfeSh_r && !modeSh_r
            && irqRequest && !vectorFetchAck);
    endsequence

    a_reset_values: assert property ($fell(rst) |-> !irqRequest && intPinPullupEn && !sharedPinPullupEn)
        else $error("outputs wrong after reset");
    a_edge_sets: assert property (
        intPinN[*5] ##1 (!intPinN && !wrPend_r && !vectorFetchAck && !maskSh_r)[*8] |-> irqRequest)
        else $error("falling edge did not raise the request");
    a_fetch_clears: assert property (s_quiet ##0 (vectorFetchAck && !modeSh_r) |-> ##2 !irqRequest)
        else $error("fetch did not clear the request");
    a_soft_clear: assert property (s_quiet ##0 (wrSc && hwdata[2] && !breakActive) |-> ##2 !irqRequest)
        else $error("software clear failed");
    a_break_holds: assert property (s_breakClr |-> ##1 irqRequest)
        else $error("clear in break took effect");
    a_level_holds: assert property ((modeSh_r && !maskSh_r && !intPinN)[*8] |-> irqRequest)
        else $error("low level did not hold the request");
    a_mask_blocks: assert property (maskSh_r && $past(maskSh_r) |-> !irqRequest)
        else $error("masked request forwarded");
    a_pullup_bit: assert property (intPinPullupEn == !pdisSh_r)
        else $error("dedicated pullup wrong");
    a_shared_input: assert property (
        sharedPinForceInput == shEn && sharedPinPullupEn == sharedPinForceInput)
        else $error("shared pin setup wrong");
endmodule

bind eirq_latch eirq_latch_monitor mon (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .intPinN, .sharedPortPin,
    .vectorFetchAck, .breakActive, .irqRequest, .intPinPullupEn, .sharedPinPullupEn, .sharedPinForceInput
);

// ---- tb/eirq_pin_src.sv ----
/* Far-side model: two interrupt sources that switch their pin to ground.
   Assumes a pullup holds each released pin high. */
module eirq_pin_src (
    input  wire logic [1:0] lowReq,               // Bit 0 pulls the dedicated pin, bit 1 the shared one.
    input  wire logic       clk_sys,              // Clock pacing the switches.
    output logic            intPinN = 1'b1,       // Dedicated pin level.
    output logic            sharedPortPin = 1'b1  // Shared pin level.
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin returns to the pulled-up high level.
    always @(posedge clk_sys) begin
        intPinN <= ~lowReq[0];
        sharedPortPin <= ~lowReq[1];
    end
endmodule

// ---- tb/external_interrupt_latch_test.sv ----
/* Testbench for the external interrupt latch: registers over AHB-Lite, sensing modes,
   mask, acknowledges, break protection and the shared pin. Assumes the pin source model. */
module external_interrupt_latch_test
    import eirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SC = EIRQ_STATUS_CTRL_OFS;
    localparam logic [7:0] OP = EIRQ_OPTION_OFS;
    localparam logic [7:0] SY = EIRQ_SYS_CTRL_OFS;
    logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        vectorFetchAck = 1'b0, breakActive = 1'b0;
    logic [1:0]  htrans = 2'h0, lowReq = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic        hreadyout, hresp, irqRequest, intPinN, sharedPortPin;
    logic        intPinPullupEn, sharedPinPullupEn, sharedPinForceInput;
    logic [15:0] vectorAddr;
    int          failures = 0;
    int          cmp_count = 0;

    // Free-running 250 MHz clock.
    always #2 clk_sys = ~clk_sys;

    eirq_latch #(.SYNC_STAGES(3)) dut (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .intPinN(intPinN), .sharedPortPin(sharedPortPin), .vectorFetchAck(vectorFetchAck),
        .breakActive(breakActive), .irqRequest(irqRequest), .vectorAddr(vectorAddr),
        .intPinPullupEn(intPinPullupEn), .sharedPinPullupEn(sharedPinPullupEn),
        .sharedPinForceInput(sharedPinForceInput)
    );
    eirq_pin_src src (.lowReq(lowReq), .clk_sys(clk_sys), .intPinN(intPinN), .sharedPortPin(sharedPortPin));

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic irq(input logic e);
        chk({31'h0, irqRequest}, {31'h0, e});
    endtask
    // Single word transfer; each phase is held until hready is seen high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= EIRQ_HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Sets which pins are pulled low and lets the change pass the synchroniser.
    task automatic pin(input logic [1:0] low);
        lowReq <= low;
        repeat (10) @(posedge clk_sys);
    endtask
    // One-cycle vector fetch acknowledge.
    task automatic ack;
        vectorFetchAck <= 1'b1;
        @(posedge clk_sys);
        vectorFetchAck <= 1'b0;
    endtask
    task automatic waitOut;
        repeat (2) @(posedge clk_sys);
    endtask

    // Reset values, an unmapped place, and the pullup, response and vector outputs.
    task automatic t_regs;
        rc(SC, 32'h0);
        rc(OP, 32'h0);
        rc(SY, 32'h0);
        xfer(1'b1, 8'h40, 32'hff);
        rc(8'h40, 32'h0);
        chk({30'h0, intPinPullupEn, sharedPinForceInput}, 32'h2);
        chk({15'h0, hresp, vectorAddr}, {15'h0, EIRQ_HRESP_OKAY, EIRQ_VECTOR_HI_ADDR});
    endtask
    // Edge mode: latch, poll, software clear, then a fresh edge.
    task automatic t_edge;
        pin(2'b01);
        pin(2'b00);
        irq(1'b1);
        rc(SC, 32'h8);
        xfer(1'b1, SC, 32'h4);
        waitOut;
        irq(1'b0);
        pin(2'b01);
        irq(1'b1);
        xfer(1'b1, SC, 32'h4);
        pin(2'b00);
        irq(1'b0);
    endtask
    // Masked request is pending but not forwarded; a fetch clears it.
    task automatic t_mask;
        xfer(1'b1, SC, 32'h2);
        pin(2'b01);
        pin(2'b00);
        irq(1'b0);
        rc(SC, 32'ha);
        ack;
        rc(SC, 32'h2);
        xfer(1'b1, SC, 32'h0);
        waitOut;
        irq(1'b0);
    endtask
    // Level mode holds while low, clears after acknowledge and release; reset drops it.
    task automatic t_level;
        xfer(1'b1, SC, 32'h1);
        pin(2'b01);
        irq(1'b1);
        ack;
        repeat (4) @(posedge clk_sys);
        irq(1'b1);
        pin(2'b00);
        irq(1'b0);
        pin(2'b01);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        irq(1'b0);
        rc(SC, 32'h0);
        pin(2'b00);
    endtask
    // Break protects the latch unless clearing in break is enabled.
    task automatic t_break;
        pin(2'b01);
        pin(2'b00);
        breakActive <= 1'b1;
        xfer(1'b1, SC, 32'h4);
        waitOut;
        irq(1'b1);
        xfer(1'b1, SY, 32'h2);
        xfer(1'b1, SC, 32'h4);
        breakActive <= 1'b0;
        waitOut;
        irq(1'b0);
        xfer(1'b1, SY, 32'h0);
    endtask
    // Shared pin setup, its edge flag, and its gating by the USB function.
    task automatic t_shared;
        xfer(1'b1, OP, 32'h2);
        waitOut;
        chk({30'h0, sharedPinPullupEn, sharedPinForceInput}, 32'h3);
        pin(2'b10);
        pin(2'b00);
        irq(1'b1);
        rc(OP, 32'h6);
        rc(OP, 32'h2);
        xfer(1'b1, SC, 32'h4);
        xfer(1'b1, SY, 32'h1);
        pin(2'b10);
        pin(2'b00);
        irq(1'b0);
        xfer(1'b1, SY, 32'h0);
        xfer(1'b1, OP, 32'h1);
        waitOut;
        chk({30'h0, intPinPullupEn, sharedPinForceInput}, 32'h0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence after two reset cycles.
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        t_edge;
        t_mask;
        t_level;
        t_break;
        t_shared;
        finish_test;
    end
    // Cuts a hung run short.
    initial begin
        #60000;
        failures++;
        finish_test;
    end
endmodule
